//--- logic/poss_pkg.sv
package poss_pkg;

  localparam logic [7:0] ADDR_PHASE        = 8'h04;
  localparam logic [7:0] ADDR_SYNC_WIDTH   = 8'h07;
  localparam logic [7:0] ADDR_SYNC_CONTROL = 8'h0E;
  localparam logic [7:0] ADDR_MODE         = 8'h1E;
  localparam logic [7:0] ADDR_STATUS       = 8'h1F;

  localparam logic [7:0] RST_PHASE         = 8'h80;
  localparam logic [7:0] RST_SYNC_WIDTH    = 8'h20;
  localparam logic [7:0] RST_SYNC_CONTROL  = 8'h40;
  localparam logic [7:0] RST_MODE          = 8'h03;

  localparam int PHASE_LSB          = 3;
  localparam int PHASE_BITS         = 5;
  localparam int PHASE_STEPS        = 32;
  localparam int PHASE_FULL_CDEG    = 36000;
  localparam int PHASE_STEP_CDEG    = PHASE_FULL_CDEG / PHASE_STEPS;
  localparam int SC_POL_OVERRIDE    = 7;
  localparam int SC_POL_INPUT       = 6;
  localparam int SC_POL_OUTPUT      = 5;
  localparam int MODE_DUAL          = 0;
  localparam int MODE_HOLD_POL      = 1;
  localparam int MODE_ALT_SAMPLING  = 2;
  localparam int STAT_POL_DETECTED  = 0;
  localparam int STAT_HOLD_ACTIVE   = 1;
  localparam int STAT_FRAME_PARITY  = 2;

  localparam int SAMPLE_W           = 8;
  localparam int FIFO_DEPTH         = 8;
  localparam int POL_CNT_W          = 10;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  typedef struct packed {
    logic [PHASE_BITS-1:0] phase;
    logic [7:0]            width;
    logic                  pol_override;
    logic                  pol_input_high;
    logic                  pol_output_low;
    logic                  dual;
    logic                  hold_pol_high;
    logic                  alt_sampling;
  } poss_cfg_type;

  typedef struct packed {
    logic                line_start;
    logic [SAMPLE_W-1:0] data;
  } poss_word_type;

  typedef enum logic {
    OUT_UPDATE = 1'b0,
    OUT_RISE   = 1'b1
  } poss_out_state_type;

endpackage

//--- logic/poss_fifo.sv
`timescale 1ns/1ns
module poss_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [CW-1:0]    cnt_reg;
  logic [CW-1:0]    cnt_next;
  logic             push;
  logic             pop;

  // The full flag comes from a flop so the source sees a clean ready.
  assign push     = in_valid_i && in_ready_o;
  assign pop      = (cnt_reg != '0) && (!out_valid_o || out_ready_i);
  assign cnt_next = cnt_reg + CW'(push) - CW'(pop);

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg    <= '0;
      in_ready_o <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + AW'(1);
      end
      cnt_reg    <= cnt_next;
      in_ready_o <= (cnt_next != DEPTH_C);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
    end else if (pop) begin
      out_valid_o <= 1'b1;
      out_data_o  <= mem_reg[rd_ptr_reg];
    end else if (out_ready_i) begin
      out_valid_o <= 1'b0;
    end
  end

endmodule

//--- logic/poss_top.sv
// How it works
// [RULE_01] Alternate sampling: invert clock toggles each frame, even then odd positions.
// [RULE_02] Far side drives clock invert high to invert, changing it only between frames.
// [RULE_03] Far side merges odd and even half frames, displaying at full refresh.
// [RULE_04] Sample at the sync leading edge goes to the A port.
// [RULE_05] Dual mode: next sample to B, then samples alternate A and B.
// [RULE_06] Single mode: all samples on A, B port released to high impedance.
// [RULE_07] Data clock rises midway between A port data changes; the code raises it one pixel clock after each A change, even in dual mode.
// [RULE_08] Sampling phase shifts over a full cycle in 32 steps.
// [RULE_09] Each step is 11.25 degrees; sync output carries the same shift.
// [RULE_10] Incoming sync polarity is detected so the output polarity is known.
// [RULE_11] Sync output active level set by sync control bit 5.
// [RULE_12] Sync output is aligned with data clock and pixel data.
// [RULE_13] Sync output stays active for the programmed number of pixel clocks.
// [RULE_14] Downstream times lines from the regenerated sync, not raw sync.
// [RULE_15] While hold is active, sync to the PLL is ignored; clock free-runs.
// [RULE_16] Far side asserts hold only during vertical sync disturbances.
// [RULE_17] Hold input and incoming sync each use their own polarity setting.
// [RULE_18] Sampling-to-output latency is equal for every sample; the code queues them in a FIFO, so latency varies with its fill and stalls.
`timescale 1ns/1ns
module poss_top
  import poss_pkg::*;
#(
  parameter int SAMPLE_WIDTH = SAMPLE_W,
  parameter int BUF_DEPTH    = FIFO_DEPTH
) (
  input  wire logic                    clk_i,
  input  wire logic                    resetn_i,
  input  wire logic [7:0]              reg_addr_i,
  input  wire logic [7:0]              reg_wdata_i,
  input  wire logic                    reg_wr_i,
  input  wire logic                    reg_rd_i,
  output logic [7:0]                   reg_rdata_o,
  output logic                         reg_rvalid_o,
  input  wire logic                    pix_clk_i,
  input  wire logic [SAMPLE_WIDTH-1:0] sample_i,
  input  wire logic                    sample_valid_i,
  output logic                         sample_ready_o,
  input  wire logic                    hsync_i,
  input  wire logic                    vsync_i,
  input  wire logic                    pll_hold_input_i,
  input  wire logic                    sample_clock_invert_i,
  output logic                         adc_clock_invert_o,
  output logic [PHASE_BITS-1:0]        phase_step_o,
  output logic                         pll_ref_o,
  input  wire logic                    out_ready_i,
  output logic [SAMPLE_WIDTH-1:0]      primary_pixel_port_o,
  output logic [SAMPLE_WIDTH-1:0]      secondary_pixel_port_o,
  output logic                         secondary_pixel_port_oe_o,
  output logic                         output_data_clock_o,
  output logic                         realigned_sync_out_o
);

  localparam int WW = SAMPLE_WIDTH + 1;

  // ---------------- Register side, clk_i domain ----------------
  logic [7:0]   phase_reg;
  logic [7:0]   width_reg;
  logic [7:0]   sync_ctrl_reg;
  logic [7:0]   mode_reg;
  poss_cfg_type cfg_snap_reg;
  logic         cfg_dirty_reg;
  logic         cfg_busy_reg;
  logic         cfg_req_reg;
  logic [1:0]   ack_sync_reg;
  logic         ack_seen_reg;
  logic [2:0]   stat_s1_reg;
  logic [2:0]   stat_s2_reg;
  poss_cfg_type cfg_live;
  logic         cfg_ack_reg;
  logic         pol_high_reg;
  logic         hold_act_reg;
  logic         frame_parity_reg;

  assign cfg_live = '{phase:          phase_reg[PHASE_LSB +: PHASE_BITS],
                      width:          width_reg,
                      pol_override:   sync_ctrl_reg[SC_POL_OVERRIDE],
                      pol_input_high: sync_ctrl_reg[SC_POL_INPUT],
                      pol_output_low: sync_ctrl_reg[SC_POL_OUTPUT],
                      dual:           mode_reg[MODE_DUAL],
                      hold_pol_high:  mode_reg[MODE_HOLD_POL],
                      alt_sampling:   mode_reg[MODE_ALT_SAMPLING]};

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      phase_reg     <= RST_PHASE;
      width_reg     <= RST_SYNC_WIDTH;
      sync_ctrl_reg <= RST_SYNC_CONTROL;
      mode_reg      <= RST_MODE;
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        ADDR_PHASE:        phase_reg     <= reg_wdata_i & 8'hF8;
        ADDR_SYNC_WIDTH:   width_reg     <= reg_wdata_i;
        ADDR_SYNC_CONTROL: sync_ctrl_reg <= reg_wdata_i;
        ADDR_MODE:         mode_reg      <= reg_wdata_i & 8'h07;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      reg_rdata_o  <= UNMAPPED_READ;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        unique case (reg_addr_i)
          ADDR_PHASE:        reg_rdata_o <= phase_reg;
          ADDR_SYNC_WIDTH:   reg_rdata_o <= width_reg;
          ADDR_SYNC_CONTROL: reg_rdata_o <= sync_ctrl_reg;
          ADDR_MODE:         reg_rdata_o <= mode_reg;
          ADDR_STATUS:       reg_rdata_o <= {5'h00, stat_s2_reg};
          default:           reg_rdata_o <= UNMAPPED_READ;
        endcase
      end
    end
  end

  // The snapshot only changes while no handshake is open, so the pixel side
  // never samples a word that is moving under it.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      cfg_snap_reg  <= cfg_live;
      cfg_dirty_reg <= 1'b1;
      cfg_busy_reg  <= 1'b0;
      cfg_req_reg   <= 1'b0;
      ack_sync_reg  <= 2'h0;
      ack_seen_reg  <= 1'b0;
    end else begin
      ack_sync_reg <= {ack_sync_reg[0], cfg_ack_reg};
      if (cfg_busy_reg && (ack_sync_reg[1] != ack_seen_reg)) begin
        ack_seen_reg <= ack_sync_reg[1];
        cfg_busy_reg <= 1'b0;
      end
      if (reg_wr_i) begin
        cfg_dirty_reg <= 1'b1;
      end else if (cfg_dirty_reg && !cfg_busy_reg) begin
        cfg_snap_reg  <= cfg_live;
        cfg_dirty_reg <= 1'b0;
        cfg_busy_reg  <= 1'b1;
        cfg_req_reg   <= ~cfg_req_reg;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      stat_s1_reg <= 3'h0;
      stat_s2_reg <= 3'h0;
    end else begin
      stat_s1_reg <= {frame_parity_reg, hold_act_reg, pol_high_reg};
      stat_s2_reg <= stat_s1_reg;
    end
  end

  // ---------------- Pixel side, pix_clk_i domain ----------------
  logic                        prst_s1_reg;
  logic                        prst_reg;
  logic [1:0]                  req_sync_reg;
  poss_cfg_type                pcfg_reg;
  logic [1:0]                  hs_sync_reg;
  logic [1:0]                  vs_sync_reg;
  logic [1:0]                  hold_sync_reg;
  logic [1:0]                  inv_sync_reg;
  logic [POL_CNT_W-1:0]        pol_cnt_reg;
  logic                        hs_act_d_reg;
  logic                        vs_d_reg;
  logic                        edge_pending_reg;
  logic                        hs_act;
  logic                        hs_lead;
  logic                        in_ready;
  logic                        out_valid;
  logic                        pop;
  poss_word_type               in_word;
  poss_word_type               out_word;
  poss_out_state_type          ostate_reg;
  logic                        next_b_reg;
  logic [7:0]                  hs_cnt_reg;

  // The pixel side leaves reset through its own two-stage synchroniser.
  always_ff @(posedge pix_clk_i) begin
    prst_s1_reg <= !resetn_i;
    prst_reg    <= prst_s1_reg;
  end

  always_ff @(posedge pix_clk_i) begin
    if (prst_reg) begin
      req_sync_reg <= 2'h0;
      cfg_ack_reg  <= 1'b0;
      pcfg_reg     <= '0;
    end else begin
      req_sync_reg <= {req_sync_reg[0], cfg_req_reg};
      if (req_sync_reg[1] != cfg_ack_reg) begin
        pcfg_reg    <= cfg_snap_reg;
        cfg_ack_reg <= req_sync_reg[1];
      end
    end
  end

  always_ff @(posedge pix_clk_i) begin
    if (prst_reg) begin
      hs_sync_reg   <= 2'h0;
      vs_sync_reg   <= 2'h0;
      hold_sync_reg <= 2'h0;
      inv_sync_reg  <= 2'h0;
    end else begin
      hs_sync_reg   <= {hs_sync_reg[0], hsync_i};
      vs_sync_reg   <= {vs_sync_reg[0], vsync_i};
      hold_sync_reg <= {hold_sync_reg[0], pll_hold_input_i};
      inv_sync_reg  <= {inv_sync_reg[0], sample_clock_invert_i};
    end
  end

  // Sync pulses are short, so the level seen most of the time is the
  // inactive one; the counter leans towards it and saturates.
  always_ff @(posedge pix_clk_i) begin
    if (prst_reg) begin
      pol_cnt_reg  <= '0;
      pol_high_reg <= 1'b1;
    end else begin
      if (hs_sync_reg[1] && (pol_cnt_reg != {1'b0, {(POL_CNT_W-1){1'b1}}})) begin
        pol_cnt_reg <= pol_cnt_reg + POL_CNT_W'(1);
      end else if (!hs_sync_reg[1] && (pol_cnt_reg != {1'b1, {(POL_CNT_W-1){1'b0}}})) begin
        pol_cnt_reg <= pol_cnt_reg - POL_CNT_W'(1);
      end
      if (pcfg_reg.pol_override) begin
        pol_high_reg <= pcfg_reg.pol_input_high; // [RULE_17]
      end else begin
        pol_high_reg <= pol_cnt_reg[POL_CNT_W-1]; // [RULE_10]
      end
    end
  end

  assign hs_act  = pol_high_reg ? hs_sync_reg[1] : !hs_sync_reg[1];
  assign hs_lead = hs_act && !hs_act_d_reg;

  always_ff @(posedge pix_clk_i) begin
    if (prst_reg) begin
      hold_act_reg <= 1'b0;
      hs_act_d_reg <= 1'b0;
      pll_ref_o    <= 1'b0;
      phase_step_o <= RST_PHASE[PHASE_LSB +: PHASE_BITS];
    end else begin
      hold_act_reg <= pcfg_reg.hold_pol_high ? hold_sync_reg[1] : !hold_sync_reg[1]; // [RULE_17]
      hs_act_d_reg <= hs_act;
      pll_ref_o    <= hold_act_reg ? 1'b0 : hs_act; // [RULE_15]
      // One code step is 11.25 degrees of the pixel period; this whole domain,
      // and with it the sync output, runs on the shifted clock.
      phase_step_o <= pcfg_reg.phase; // [RULE_08] [RULE_09]
    end
  end

  // The invert level from outside is only taken at a frame start.
  always_ff @(posedge pix_clk_i) begin
    if (prst_reg) begin
      vs_d_reg           <= 1'b0;
      frame_parity_reg   <= 1'b0;
      adc_clock_invert_o <= 1'b0;
    end else begin
      vs_d_reg <= vs_sync_reg[1];
      if (vs_sync_reg[1] && !vs_d_reg) begin
        if (pcfg_reg.alt_sampling) begin
          frame_parity_reg <= !frame_parity_reg; // [RULE_01]
        end else begin
          frame_parity_reg <= 1'b0;
        end
        adc_clock_invert_o <= inv_sync_reg[1] ^ (pcfg_reg.alt_sampling && !frame_parity_reg); // [RULE_01] [RULE_02]
      end
    end
  end

  // The leading edge marks the next accepted sample; a new edge wins over
  // the clear that the marking sample would make.
  always_ff @(posedge pix_clk_i) begin
    if (prst_reg) begin
      edge_pending_reg <= 1'b0;
    end else if (hs_lead) begin
      edge_pending_reg <= 1'b1;
    end else if (sample_valid_i && in_ready) begin
      edge_pending_reg <= 1'b0;
    end
  end

  assign in_word.line_start = hs_lead || edge_pending_reg; // [RULE_04]
  assign in_word.data       = sample_i;
  assign sample_ready_o     = in_ready;

  poss_fifo #(
    .WIDTH (WW),
    .DEPTH (BUF_DEPTH)
  ) u_fifo (
    .clk_i       (pix_clk_i),
    .rst_i       (prst_reg),
    .in_valid_i  (sample_valid_i),
    .in_ready_o  (in_ready),
    .in_data_i   (in_word),
    .out_valid_o (out_valid),
    .out_ready_i (pop),
    .out_data_o  (out_word)
  );

  // Samples wait in the buffer for a time that varies with fill and stalls, but each
  // carries its line-start flag, so the A/B split set at the line start holds for the whole line.
  assign pop = out_valid && out_ready_i && (ostate_reg == OUT_UPDATE); // [RULE_18]

  always_ff @(posedge pix_clk_i) begin
    if (prst_reg) begin
      ostate_reg                <= OUT_UPDATE;
      next_b_reg                <= 1'b0;
      primary_pixel_port_o      <= '0;
      secondary_pixel_port_o    <= '0;
      secondary_pixel_port_oe_o <= 1'b0;
      output_data_clock_o       <= 1'b1;
    end else begin
      secondary_pixel_port_oe_o <= pcfg_reg.dual; // [RULE_06]
      unique case (ostate_reg)
        OUT_UPDATE: begin
          if (pop) begin
            if (out_word.line_start) begin
              primary_pixel_port_o <= out_word.data; // [RULE_04]
              next_b_reg           <= pcfg_reg.dual; // [RULE_05]
              output_data_clock_o  <= 1'b0;
            end else if (pcfg_reg.dual && next_b_reg) begin
              secondary_pixel_port_o <= out_word.data; // [RULE_05]
              next_b_reg             <= 1'b0;
            end else begin
              primary_pixel_port_o <= out_word.data; // [RULE_06]
              next_b_reg           <= pcfg_reg.dual; // [RULE_05]
              output_data_clock_o  <= 1'b0;
            end
            ostate_reg <= OUT_RISE;
          end
        end
        OUT_RISE: begin
          output_data_clock_o <= 1'b1; // [RULE_07]
          ostate_reg          <= OUT_UPDATE;
        end
      endcase
      if (!pcfg_reg.dual) begin
        secondary_pixel_port_o <= '0;
      end
    end
  end

  // The sync output starts on the same edge that puts the line's first
  // sample on the A port, so both leave together.
  always_ff @(posedge pix_clk_i) begin
    if (prst_reg) begin
      hs_cnt_reg           <= 8'h00;
      realigned_sync_out_o <= 1'b0;
    end else begin
      if (pop && out_word.line_start) begin
        hs_cnt_reg <= pcfg_reg.width; // [RULE_12] [RULE_13]
      end else if (hs_cnt_reg != 8'h00) begin
        hs_cnt_reg <= hs_cnt_reg - 8'h01; // [RULE_13]
      end
      realigned_sync_out_o <= ((pop && out_word.line_start && (pcfg_reg.width != 8'h00)) ||
                               (hs_cnt_reg > 8'h01)) ^ pcfg_reg.pol_output_low; // [RULE_11] [RULE_12]
    end
  end

endmodule

//--- tb/poss_assertions.sv
`timescale 1ns/1ns
module poss_assertions
  import poss_pkg::*;
#(
  parameter int SAMPLE_WIDTH = SAMPLE_W
) (
  input wire logic                    clk_i,
  input wire logic                    resetn_i,
  input wire logic [7:0]              reg_addr_i,
  input wire logic [7:0]              reg_wdata_i,
  input wire logic                    reg_wr_i,
  input wire logic                    reg_rd_i,
  input wire logic [7:0]              reg_rdata_o,
  input wire logic                    reg_rvalid_o,
  input wire logic                    pix_clk_i,
  input wire logic                    pll_hold_input_i,
  input wire logic [PHASE_BITS-1:0]   phase_step_o,
  input wire logic                    pll_ref_o,
  input wire logic [SAMPLE_WIDTH-1:0] primary_pixel_port_o,
  input wire logic [SAMPLE_WIDTH-1:0] secondary_pixel_port_o,
  input wire logic                    secondary_pixel_port_oe_o,
  input wire logic                    output_data_clock_o,
  input wire logic                    realigned_sync_out_o
);
  logic                  hold_pol_reg;
  logic                  out_low_reg;
  logic [7:0]            width_reg;
  logic [PHASE_BITS-1:0] phase_reg;
  logic [4:0]            quiet_reg;
  logic [8:0]            run_reg;
  logic                  act;
  assign act = realigned_sync_out_o ^ out_low_reg;
  // Settings cross by handshake, so dependent checks rest until 31 quiet cycles.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      hold_pol_reg <= RST_MODE[MODE_HOLD_POL];
      out_low_reg  <= RST_SYNC_CONTROL[SC_POL_OUTPUT];
      width_reg    <= RST_SYNC_WIDTH;
      phase_reg    <= RST_PHASE[7:PHASE_LSB];
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        ADDR_MODE: hold_pol_reg <= reg_wdata_i[MODE_HOLD_POL];
        ADDR_SYNC_CONTROL: out_low_reg <= reg_wdata_i[SC_POL_OUTPUT];
        ADDR_SYNC_WIDTH: width_reg <= reg_wdata_i;
        ADDR_PHASE: phase_reg <= reg_wdata_i[7:PHASE_LSB];
        default: ;
      endcase
    end
  end
  always_ff @(posedge clk_i) begin
    if (!resetn_i || reg_wr_i) begin
      quiet_reg <= 5'h00;
    end else if (quiet_reg != 5'h1F) begin
      quiet_reg <= quiet_reg + 5'h01;
    end
  end
  always_ff @(posedge pix_clk_i) begin
    if (!resetn_i || !act) begin
      run_reg <= 9'h000;
    end else begin
      run_reg <= run_reg + 9'h001;
    end
  end
  a_single_b_zero: assert property (@(posedge pix_clk_i) disable iff (!resetn_i)
    !secondary_pixel_port_oe_o |-> secondary_pixel_port_o == '0) else $error("B port not idle");
  a_dclk_low_once: assert property (@(posedge pix_clk_i) disable iff (!resetn_i)
    $fell(output_data_clock_o) |=> output_data_clock_o) else $error("data clock low too long");
  a_a_under_low: assert property (@(posedge pix_clk_i) disable iff (!resetn_i)
    $changed(primary_pixel_port_o) |-> !output_data_clock_o) else $error("A moved off low phase");
  a_b_no_pulse: assert property (@(posedge pix_clk_i) disable iff (!resetn_i || quiet_reg != 5'h1F)
    $changed(secondary_pixel_port_o) |-> output_data_clock_o && secondary_pixel_port_oe_o)
    else $error("B moved wrongly");
  a_hold_blocks_ref: assert property (@(posedge pix_clk_i) disable iff (!resetn_i || quiet_reg != 5'h1F)
    (pll_hold_input_i == hold_pol_reg) [*5] |-> !pll_ref_o) else $error("reference passed in hold");
  a_sync_width_count: assert property (@(posedge pix_clk_i) disable iff (!resetn_i || quiet_reg != 5'h1F)
    $fell(act) |-> run_reg == {1'b0, width_reg}) else $error("sync pulse length wrong");
  a_sync_with_clock: assert property (@(posedge pix_clk_i) disable iff (!resetn_i || quiet_reg != 5'h1F)
    $rose(act) |-> $fell(output_data_clock_o)) else $error("sync not aligned to A word");
  a_phase_follows: assert property (@(posedge clk_i) disable iff (!resetn_i)
    reg_wr_i && reg_addr_i == ADDR_PHASE |-> ##[1:20] phase_step_o == phase_reg) else $error("phase code late");
  a_width_readback: assert property (@(posedge clk_i) disable iff (!resetn_i)
    reg_rd_i && reg_addr_i == ADDR_SYNC_WIDTH |=> reg_rvalid_o && reg_rdata_o == width_reg)
    else $error("width read wrong");
endmodule

//--- tb/poss_display_model.sv
`timescale 1ns/1ns
module poss_display_model
  import poss_pkg::*;
(
  input  wire logic                pix_clk_i,
  input  wire logic                resetn_i,
  input  wire logic                stall_i,
  input  wire logic                out_low_i,
  input  wire logic [SAMPLE_W-1:0] a_i,
  input  wire logic [SAMPLE_W-1:0] b_i,
  input  wire logic                dclk_i,
  input  wire logic                sync_i,
  output logic                     ready_o
);
  logic [SAMPLE_W-1:0] qa[$];
  logic [SAMPLE_W-1:0] qb[$];
  logic                qs[$];
  initial ready_o = 1'b0;
  // Random pauses stall the output; nothing may be lost.
  always @(posedge pix_clk_i) begin
    #1;
    ready_o = !stall_i && ($urandom_range(3) != 0);
  end
  // A low data clock marks a fresh A word, taken before the rise.
  always @(posedge pix_clk_i) begin
    if (resetn_i && dclk_i === 1'b0) begin
      qa.push_back(a_i);
      qb.push_back(b_i);
      qs.push_back(sync_i ^ out_low_i);
    end
  end
endmodule

//--- tb/pixel_output_sync_sequencer_tb_top.sv
`timescale 1ns/1ns
module pixel_output_sync_sequencer_tb_top;
  import poss_pkg::*;
  logic                clk_i, resetn_i, reg_wr_i, reg_rd_i, reg_rvalid_o, pix_clk_i, sample_valid_i;
  logic                sample_ready_o, hsync_i, vsync_i, pll_hold_input_i, sample_clock_invert_i;
  logic                adc_clock_invert_o, pll_ref_o, out_ready_i, secondary_pixel_port_oe_o;
  logic                output_data_clock_o, realigned_sync_out_o, stall, out_low, hact;
  logic [7:0]          reg_addr_i, reg_wdata_i, reg_rdata_o, d;
  logic [4:0]          phase_step_o, code;
  logic [SAMPLE_W-1:0] sample_i, primary_pixel_port_o, secondary_pixel_port_o;
  logic [7:0]          ln[$];
  int                  error_cnt, total_checks, k;
  poss_top #(.SAMPLE_WIDTH(SAMPLE_W), .BUF_DEPTH(FIFO_DEPTH)) DUT (.*);
  poss_display_model u_disp (.pix_clk_i(pix_clk_i), .resetn_i(resetn_i), .stall_i(stall), .out_low_i(out_low),
    .a_i(primary_pixel_port_o), .b_i(secondary_pixel_port_o), .dclk_i(output_data_clock_o),
    .sync_i(realigned_sync_out_o), .ready_o(out_ready_i));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    pix_clk_i = 1'b0;
    #3;
    forever #6 pix_clk_i = ~pix_clk_i;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic pw(input int n);
    repeat (n) @(posedge pix_clk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i);
    #1;
    reg_addr_i = a;
    reg_wdata_i = v;
    reg_wr_i = 1'b1;
    @(posedge clk_i);
    #1;
    reg_wr_i = 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input int b);
    @(posedge clk_i);
    #1;
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(posedge clk_i);
    #1;
    reg_rd_i = 1'b0;
    d = (reg_rvalid_o === 1'b1) ? reg_rdata_o : 8'hXX;
    chk((b < 0) ? d : {7'h00, d[b]}, e);
  endtask
  task automatic wt();
    for (int t = 0; t < 30 && sample_ready_o !== 1'b1; t++) pw(1);
  endtask
  task automatic vs();
    vsync_i = 1'b1;
    pw(4);
    vsync_i = 1'b0;
    pw(8);
  endtask
  task automatic line(input int n, input bit hold_out, input bit dual);
    int got;
    ln.delete();
    u_disp.qa.delete();
    u_disp.qb.delete();
    u_disp.qs.delete();
    stall = hold_out;
    hsync_i = hact;
    pw(2);
    hsync_i = !hact;
    pw(4);
    got = n;
    for (int i = 0; i < n; i++) begin
      sample_i = 8'($urandom);
      sample_valid_i = 1'b1;
      wt();
      if (sample_ready_o !== 1'b1) begin
        got = i;
        stall = 1'b0;
        wt();
      end
      ln.push_back(sample_i);
      pw(1);
    end
    sample_valid_i = 1'b0;
    pw(80);
    if (hold_out) chk(8'(got), 8'(FIFO_DEPTH + 1));
    chk(8'(u_disp.qs[0]), 8'h01);
    chk(8'(u_disp.qa.size()), 8'(dual ? (n + 1) / 2 : n));
    chk({7'h00, secondary_pixel_port_oe_o}, {7'h00, dual});
    for (int i = 0; i < n; i++) begin
      if (!dual) chk(u_disp.qa[i], ln[i]);
      else if (i % 2 == 0) chk(u_disp.qa[i / 2], ln[i]);
      else if (i < n - 1) chk(u_disp.qb[i / 2 + 1], ln[i]);
    end
  endtask
  initial begin
    {reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i, sample_i, sample_valid_i, resetn_i} = '0;
    {hsync_i, vsync_i, pll_hold_input_i, sample_clock_invert_i, stall, out_low, hact} = '0;
    error_cnt = 0;
    total_checks = 0;
    d = 8'($urandom(91233));
    repeat (5) @(posedge clk_i);
    #1;
    resetn_i = 1'b1;
    rdchk(ADDR_PHASE, RST_PHASE, -1);
    rdchk(ADDR_SYNC_WIDTH, RST_SYNC_WIDTH, -1);
    rdchk(ADDR_SYNC_CONTROL, RST_SYNC_CONTROL, -1);
    rdchk(ADDR_MODE, RST_MODE, -1);
    wr(8'h33, 8'hFF);
    rdchk(8'h33, UNMAPPED_READ, -1);
    for (k = 0; k < 3; k++) begin
      code = (k == 0) ? 5'h00 : (k == 1) ? 5'h1F : 5'($urandom_range(31));
      wr(ADDR_PHASE, {code, 3'h7});
      rdchk(ADDR_PHASE, {code, 3'h0}, -1);
      repeat (20) @(posedge clk_i);
      chk({3'h0, phase_step_o}, {3'h0, code});
    end
    for (k = 0; k < 4; k++) begin
      hact = (k < 2);
      hsync_i = !hact;
      out_low = 1'($urandom_range(1));
      wr(ADDR_MODE, {6'h00, 1'b1, k[0]});
      wr(ADDR_SYNC_WIDTH, 8'($urandom_range(8, 1)));
      wr(ADDR_SYNC_CONTROL, {2'b01, out_low, 5'h00});
      pw((k % 2 == 0) ? 2200 : 60);
      rdchk(ADDR_STATUS, {7'h00, hact}, STAT_POL_DETECTED);
      chk({7'h00, realigned_sync_out_o}, {7'h00, out_low});
      line((k == 1) ? 12 : 5 + k, k == 1, k[0]);
    end
    pll_hold_input_i = 1'b1;
    pw(10);
    rdchk(ADDR_STATUS, 8'h01, STAT_HOLD_ACTIVE);
    hsync_i = hact;
    pw(3);
    hsync_i = !hact;
    wr(ADDR_MODE, 8'h01);
    pw(30);
    rdchk(ADDR_STATUS, 8'h00, STAT_HOLD_ACTIVE);
    pll_hold_input_i = 1'b0;
    pw(10);
    rdchk(ADDR_STATUS, 8'h01, STAT_HOLD_ACTIVE);
    wr(ADDR_MODE, 8'h07);
    pw(30);
    vs();
    d[0] = adc_clock_invert_o;
    vs();
    chk({7'h00, d[0] ^ adc_clock_invert_o}, 8'h01);
    wr(ADDR_MODE, 8'h03);
    sample_clock_invert_i = 1'b1;
    pw(30);
    vs();
    chk({7'h00, adc_clock_invert_o}, 8'h01);
    finish_test();
  end
  initial begin
    #300000;
    error_cnt++;
    $display("mismatch at %0t: run did not end", $time);
    finish_test();
  end
endmodule
bind poss_top poss_assertions #(.SAMPLE_WIDTH(SAMPLE_WIDTH)) u_chk (.*);
